// ===== pwdc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PWDC_REGS_SVH
`define PWDC_REGS_SVH

`define PWDC_ADDR_DEMODULATOR_CONFIG 8'h00
`define PWDC_ADDR_IFCHF 8'h02
`define PWDC_ADDR_SYNC_LEN 8'h0c
`define PWDC_ADDR_SYNC_LO 8'h0d
`define PWDC_ADDR_SYNC_HI 8'h0e
`define PWDC_ADDR_ISR 8'h13
`define PWDC_ADDR_STATE 8'h14
`define PWDC_ADDR_WUT_DET 8'h17
`define PWDC_ADDR_WUT_RATIO 8'h18

`define PWDC_DEMODULATOR_CONFIG_TIME_CONTROL_LSB 0
`define PWDC_FSK_DEVIATION_SELECT_LSB 4
`define PWDC_IFCHF_CHF_LSB 0
`define PWDC_IFCHF_IF_BIT 3
`define PWDC_IFCHF_MOD_BIT 4
`define PWDC_STATE_XO_BIT 0
`define PWDC_STATE_WUT_BIT 1
`define PWDC_STATE_HRX_BIT 2
`define PWDC_ISR_DET_BIT 0

`define PWDC_DEMODULATOR_CONFIG_RESET 8'h00
`define PWDC_IFCHF_RESET 8'h00
`define PWDC_STATE_RESET 8'h00
`define PWDC_SYNC_LEN_RESET 4'h0
`define PWDC_SYNC_WORD_RESET 16'h0000
`define PWDC_WUT_DET_RESET 8'h00
`define PWDC_WUT_RATIO_RESET 7'h00

`define PWDC_CLK_MHZ 250
`define PWDC_DET_STEP_US 80
`define PWDC_DET_MIN_US 480
`define PWDC_DET_MIN_STEPS (`PWDC_DET_MIN_US / `PWDC_DET_STEP_US)

`endif

// ===== pwdc_pkg.sv
// types shared by the wake-up and demodulator configuration block
package pwdc_pkg;

   typedef enum logic [1:0] {
      PWDC_STANDBY = 2'b00,
      PWDC_POLL = 2'b01,
      PWDC_WAIT = 2'b10,
      PWDC_HOST_RX = 2'b11
   } pwdc_state_t;

   typedef struct packed {
      logic if_filter_select;
      logic [2:0] channel_filter_select;
      logic modulation_select;
      logic [2:0] demodulator_config_time_control;
      logic [2:0] fsk_deviation_select;
   } pwdc_cfg_t;

   typedef struct packed {
      logic [8:0] if_khz;
      logic [8:0] analog_bw_khz;
      logic [8:0] rx_bw_khz;
   } pwdc_bw_t;

   localparam logic [8:0] PWDC_IF_KHZ [2] = '{9'h190, 9'h0c8};
   localparam logic [8:0] PWDC_ABW_KHZ [2] = '{9'h15e, 9'h0af};
   localparam logic [8:0] PWDC_CHF_BW_KHZ [5] = '{9'h154, 9'h078, 9'h034, 9'h018, 9'h00c};

endpackage : pwdc_pkg

// ===== pwdc_matcher.sv
// phase-insensitive manchester sync pattern matcher
`timescale 1ns/10ps
`default_nettype none
module pwdc_matcher
   import pwdc_pkg::*;
#(
   parameter int MAX_LEN = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic bit_in,
   input wire logic bit_en,
   input wire logic [15:0] sync_pattern_word,
   input wire logic [3:0] sync_pattern_length,
   output logic match
);
   localparam int CW = $clog2(2 * MAX_LEN + 1);

   logic [2*MAX_LEN-1:0] history;
   logic [2*MAX_LEN-1:0] next_history;
   logic [2*MAX_LEN-1:0] enc;
   logic [2*MAX_LEN-1:0] mask;
   logic [CW-1:0] fill;
   logic [CW-1:0] needed;

   genvar i;
   generate
      for (i = 0; i < MAX_LEN; i++) begin : g_enc
         // raw 0 -> 10, raw 1 -> 01, newest decoded bit lowest
         assign enc[2*i] = sync_pattern_word[i];
         assign enc[2*i+1] = ~sync_pattern_word[i];
         // only raw bits length..0 take part
         assign mask[2*i] = (int'(sync_pattern_length) >= i);
         assign mask[2*i+1] = (int'(sync_pattern_length) >= i);
      end
   endgenerate

   assign next_history = {history[2*MAX_LEN-2:0], bit_in};
   assign needed = CW'(2 * (int'(sync_pattern_length) + 1));

   always_ff @(posedge sys_clk) begin
      if (!rst_n || clear) begin
         history <= '0;
      end else if (bit_en) begin
         history <= next_history;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || clear) begin
         fill <= '0;
      end else if (bit_en && fill < CW'(2 * MAX_LEN)) begin
         fill <= fill + CW'(1);
      end
   end

   // checked on every half-bit, so both half-bit phases are tried
   always_ff @(posedge sys_clk) begin
      if (!rst_n || clear) begin
         match <= 1'b0;
      end else begin
         match <= bit_en && ((fill + CW'(1)) >= needed)
                  && (((next_history ^ enc) & mask) == '0);
      end
   end
endmodule : pwdc_matcher
`default_nettype wire

// ===== pwdc_top.sv
// self-polling wake-up, data pin control and demodulator configuration
// Function
// - detection window spans 0.48 to 20.88 ms
// - length N compares pattern bits N..0 only
// - match either phase of manchester pattern
// - host receive drives oversampled demodulated data
// - data high in polling and quiet wait
// - after match, data falls on wait entry
// - status read in poll or wait: data high, timer off, standby
// - unread status repeats poll and wait cycle
// - if select picks 400 or 200 kHz
// - channel filter codes give listed bandwidths
// - modulation bit zero ask, one fsk
// - fsk deviation effective only in fsk mode
// - window programmed in 0.08 ms steps
// - length code 0..15 means 1..16 bits
// - raw bits expanded to manchester pairs
`timescale 1ns/10ps
`default_nettype none
`include "pwdc_regs.svh"
module pwdc_top
   import pwdc_pkg::*;
#(
   parameter int STEP_CYCLES = `PWDC_DET_STEP_US * `PWDC_CLK_MHZ,
   parameter int MAX_LEN = 16
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic rx_sample,
   input wire logic rx_sample_en,
   input wire logic rx_half_bit,
   input wire logic rx_half_bit_en,
   output logic data_out,
   output logic rx_active,
   output pwdc_state_t state_out,
   output pwdc_cfg_t cfg,
   output pwdc_bw_t bw
);
   localparam int DW = $clog2(STEP_CYCLES + 1);

   pwdc_state_t state;
   pwdc_state_t next_state;
   logic [7:0] demodulator_config;
   logic [7:0] if_filter_select;
   logic [7:0] power_state_control;
   logic [3:0] sync_length_value;
   logic [15:0] sync_pattern_word;
   logic [7:0] detect_window;
   logic [6:0] wait_interval;
   logic preamble_detect;
   logic [DW-1:0] step_div;
   logic step_tick;
   logic [8:0] period_steps;
   logic [8:0] det_steps;
   logic [7:0] period_cnt;
   logic [7:0] wait_periods;
   logic det_end;
   logic wait_end;
   logic match;
   logic irq_status_read;
   logic cfg_locked;
   logic wakeup_timer_enable;
   logic host_controlled_receive;

   assign irq_status_read = reg_rd && (reg_addr == `PWDC_ADDR_ISR);
   assign wakeup_timer_enable = power_state_control[`PWDC_STATE_WUT_BIT];
   assign host_controlled_receive = power_state_control[`PWDC_STATE_HRX_BIT];
   assign cfg_locked = (state == PWDC_POLL) || (state == PWDC_HOST_RX);
   // window = (code + 6) steps of 0.08 ms: 0.48 .. 20.88 ms
   assign det_steps = {1'b0, detect_window} + 9'(`PWDC_DET_MIN_STEPS);
   assign wait_periods = {1'b0, wait_interval} + 8'h01;
   assign det_end = step_tick && (period_steps == det_steps - 9'h001);
   assign wait_end = det_end && (period_cnt == wait_periods - 8'h01);

   // 0.08 ms step enable, restarted outside the timed states
   always_ff @(posedge sys_clk) begin
      if (!rst_n || next_state != state || state == PWDC_STANDBY
          || state == PWDC_HOST_RX) begin
         step_div <= '0;
         step_tick <= 1'b0;
      end else if (step_div == DW'(STEP_CYCLES - 1)) begin
         step_div <= '0;
         step_tick <= 1'b1;
      end else begin
         step_div <= step_div + DW'(1);
         step_tick <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || next_state != state) begin
         period_steps <= 9'h000;
         period_cnt <= 8'h00;
      end else if (det_end) begin
         period_steps <= 9'h000;
         period_cnt <= period_cnt + 8'h01;
      end else if (step_tick) begin
         period_steps <= period_steps + 9'h001;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         PWDC_STANDBY: begin
            if (wakeup_timer_enable) begin
               next_state = PWDC_POLL;
            end else if (host_controlled_receive) begin
               next_state = PWDC_HOST_RX;
            end
         end
         PWDC_POLL: begin
            if (irq_status_read || !wakeup_timer_enable) begin
               next_state = PWDC_STANDBY;
            end else if (det_end) begin
               next_state = PWDC_WAIT;
            end
         end
         PWDC_WAIT: begin
            if (irq_status_read || !wakeup_timer_enable) begin
               next_state = PWDC_STANDBY;
            end else if (wait_end) begin
               next_state = PWDC_POLL;
            end
         end
         PWDC_HOST_RX: begin
            if (!host_controlled_receive) begin
               next_state = PWDC_STANDBY;
            end
         end
         default: next_state = PWDC_STANDBY;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= PWDC_STANDBY;
      end else begin
         state <= next_state;
      end
   end

   pwdc_matcher #(
      .MAX_LEN(MAX_LEN)
   ) u_matcher (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(state != PWDC_POLL),
      .bit_in(rx_half_bit),
      .bit_en(rx_half_bit_en && state == PWDC_POLL),
      .sync_pattern_word(sync_pattern_word),
      .sync_pattern_length(sync_length_value),
      .match(match)
   );

   // sticky detect flag; a match in the read cycle survives the clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         preamble_detect <= 1'b0;
      end else if (match && state == PWDC_POLL) begin
         preamble_detect <= 1'b1;
      end else if (irq_status_read) begin
         preamble_detect <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_out <= 1'b1;
      end else if (state == PWDC_POLL && next_state == PWDC_WAIT) begin
         data_out <= !(preamble_detect || match);
      end else if (next_state == PWDC_WAIT) begin
         data_out <= data_out;
      end else if (next_state == PWDC_HOST_RX && state == PWDC_HOST_RX) begin
         if (rx_sample_en) begin
            data_out <= rx_sample;
         end
      end else begin
         data_out <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_active <= 1'b0;
         state_out <= PWDC_STANDBY;
      end else begin
         rx_active <= (next_state == PWDC_POLL) || (next_state == PWDC_HOST_RX);
         state_out <= next_state;
      end
   end

   // configuration is frozen while the receiver runs
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         demodulator_config <= `PWDC_DEMODULATOR_CONFIG_RESET;
         if_filter_select <= `PWDC_IFCHF_RESET;
         sync_length_value <= `PWDC_SYNC_LEN_RESET;
         sync_pattern_word <= `PWDC_SYNC_WORD_RESET;
         detect_window <= `PWDC_WUT_DET_RESET;
         wait_interval <= `PWDC_WUT_RATIO_RESET;
      end else if (reg_wr && !cfg_locked) begin
         if (reg_addr == `PWDC_ADDR_DEMODULATOR_CONFIG) begin
            demodulator_config <= reg_wdata;
         end else if (reg_addr == `PWDC_ADDR_IFCHF) begin
            if_filter_select <= reg_wdata;
         end else if (reg_addr == `PWDC_ADDR_SYNC_LEN) begin
            sync_length_value <= reg_wdata[3:0];
         end else if (reg_addr == `PWDC_ADDR_SYNC_LO) begin
            sync_pattern_word[7:0] <= reg_wdata;
         end else if (reg_addr == `PWDC_ADDR_SYNC_HI) begin
            sync_pattern_word[15:8] <= reg_wdata;
         end else if (reg_addr == `PWDC_ADDR_WUT_DET) begin
            detect_window <= reg_wdata;
         end else if (reg_addr == `PWDC_ADDR_WUT_RATIO) begin
            wait_interval <= reg_wdata[6:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         power_state_control <= `PWDC_STATE_RESET;
      end else if (irq_status_read) begin
         power_state_control[`PWDC_STATE_WUT_BIT] <= 1'b0;
      end else if (reg_wr && reg_addr == `PWDC_ADDR_STATE) begin
         power_state_control <= {5'h00, reg_wdata[2:0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `PWDC_ADDR_DEMODULATOR_CONFIG) begin
            reg_rdata <= demodulator_config;
         end else if (reg_addr == `PWDC_ADDR_IFCHF) begin
            reg_rdata <= if_filter_select;
         end else if (reg_addr == `PWDC_ADDR_SYNC_LEN) begin
            reg_rdata <= {4'h0, sync_length_value};
         end else if (reg_addr == `PWDC_ADDR_SYNC_LO) begin
            reg_rdata <= sync_pattern_word[7:0];
         end else if (reg_addr == `PWDC_ADDR_SYNC_HI) begin
            reg_rdata <= sync_pattern_word[15:8];
         end else if (reg_addr == `PWDC_ADDR_ISR) begin
            reg_rdata <= {7'h00, preamble_detect};
         end else if (reg_addr == `PWDC_ADDR_STATE) begin
            reg_rdata <= power_state_control;
         end else if (reg_addr == `PWDC_ADDR_WUT_DET) begin
            reg_rdata <= detect_window;
         end else if (reg_addr == `PWDC_ADDR_WUT_RATIO) begin
            reg_rdata <= {1'b0, wait_interval};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg <= '0;
      end else begin
         cfg.if_filter_select <= if_filter_select[`PWDC_IFCHF_IF_BIT];
         cfg.channel_filter_select <= if_filter_select[`PWDC_IFCHF_CHF_LSB +: 3];
         cfg.modulation_select <= if_filter_select[`PWDC_IFCHF_MOD_BIT];
         cfg.demodulator_config_time_control <= demodulator_config[`PWDC_DEMODULATOR_CONFIG_TIME_CONTROL_LSB +: 3];
         // deviation forced to zero in ask mode
         cfg.fsk_deviation_select <= if_filter_select[`PWDC_IFCHF_MOD_BIT]
            ? demodulator_config[`PWDC_FSK_DEVIATION_SELECT_LSB +: 3] : 3'h0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bw <= '0;
      end else begin
         bw.if_khz <= PWDC_IF_KHZ[if_filter_select[`PWDC_IFCHF_IF_BIT]];
         bw.analog_bw_khz <= PWDC_ABW_KHZ[if_filter_select[`PWDC_IFCHF_IF_BIT]];
         if (if_filter_select[`PWDC_IFCHF_CHF_LSB +: 3] > 3'h4) begin
            bw.rx_bw_khz <= 9'h000;
         end else begin
            bw.rx_bw_khz <= PWDC_CHF_BW_KHZ[if_filter_select[`PWDC_IFCHF_CHF_LSB +: 3]]
               >> if_filter_select[`PWDC_IFCHF_IF_BIT];
         end
      end
   end
endmodule : pwdc_top
`default_nettype wire

// ===== pwdc_top_assertions.sv
// assertion checker for the wake-up block ports
`timescale 1ns/10ps
`default_nettype none
module pwdc_top_assertions
   import pwdc_pkg::*;
#(
   parameter int STEP_CYCLES = 20000
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic rx_sample,
   input wire logic rx_sample_en,
   input wire logic data_out,
   input wire pwdc_state_t state_out,
   input wire pwdc_cfg_t cfg,
   input wire pwdc_bw_t bw
);
   localparam int MINW = 6 * STEP_CYCLES - 1;
   localparam int MAXW = 261 * STEP_CYCLES + 2;
   pwdc_state_t st_q;
   int dwell;
   logic [1:0] up;
   // dwell counts cycles spent in the state now held in st_q
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st_q <= PWDC_STANDBY;
         dwell <= 0;
         up <= 2'h0;
      end else begin
         st_q <= state_out;
         dwell <= (state_out != st_q) ? 1 : dwell + 1;
         up <= (up == 2'h3) ? up : up + 2'h1;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   a_poll_high: assert property (state_out == PWDC_POLL |-> data_out)
      else $error("data low while polling");
   a_low_hold: assert property (state_out == PWDC_WAIT && !data_out && !reg_rd && !reg_wr
      |=> !data_out || state_out == PWDC_POLL)
      else $error("wake flag on data released early");
   a_isr_clear: assert property (reg_rd && reg_addr == 8'h13 && state_out == PWDC_WAIT
      |=> state_out == PWDC_STANDBY && data_out)
      else $error("status read did not return to standby");
   a_host_stream: assert property (state_out == PWDC_HOST_RX && st_q == PWDC_HOST_RX
      && rx_sample_en && !reg_wr |=> data_out == $past(rx_sample))
      else $error("data pin does not follow sample");
   a_poll_window: assert property (state_out == PWDC_WAIT && st_q == PWDC_POLL
      |-> dwell >= MINW && dwell <= MAXW)
      else $error("poll window out of range");
   a_wait_window: assert property (state_out == PWDC_POLL && st_q == PWDC_WAIT
      |-> dwell >= MINW)
      else $error("wait shorter than one window");
   a_fsk_zero: assert property (!cfg.modulation_select |-> cfg.fsk_deviation_select == 3'h0)
      else $error("deviation active in ask mode");
   a_if_bw: assert property (up == 2'h3 && $stable(cfg) |-> bw.if_khz ==
      (cfg.if_filter_select ? 9'h0c8 : 9'h190) && bw.analog_bw_khz ==
      (cfg.if_filter_select ? 9'h0af : 9'h15e))
      else $error("if or analog bandwidth wrong");
   a_chf_bw: assert property (up == 2'h3 && $stable(cfg) && cfg.channel_filter_select == 3'h0
      |-> bw.rx_bw_khz == (cfg.if_filter_select ? 9'h0aa : 9'h154))
      else $error("widest filter bandwidth wrong");
endmodule : pwdc_top_assertions

bind pwdc_top pwdc_top_assertions #(.STEP_CYCLES(STEP_CYCLES)) chk_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .rx_sample(rx_sample), .rx_sample_en(rx_sample_en),
   .data_out(data_out), .state_out(state_out), .cfg(cfg), .bw(bw));
`default_nettype wire

// ===== pwdc_host.sv
// host controller model on the register port and data pin
`timescale 1ns/10ps
`default_nettype none
module pwdc_host (
   input wire logic sys_clk,
   input wire logic data_out,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   logic auto = 1'b0;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // released lines do not keep the last value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : xfer
   // wake on falling data, clear status, start streaming
   always @(negedge data_out) begin
      if (auto) begin
         xfer(1'b0, 8'h13, 8'h00);
         xfer(1'b1, 8'h14, 8'h04);
         auto = 1'b0;
      end
   end
endmodule : pwdc_host
`default_nettype wire

// ===== pwdc_top_test.sv
// self-checking bench for the wake-up block
`timescale 1ns/10ps
`default_nettype none
module pwdc_top_test import pwdc_pkg::*;;
   localparam int STEP = 4;
   localparam logic [15:0] WTAB [4] = '{16'h00ff, 16'h0000, 16'ha5f0, 16'h00ff};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd, data_out, rx_active;
   logic rx_sample = 1'b0, rx_sample_en = 1'b0, rx_half_bit = 1'b0, rx_half_bit_en = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, last02;
   pwdc_state_t state_out;
   pwdc_cfg_t cfg;
   pwdc_bw_t bw;
   int error_cnt = 0, n_checks = 0, cyc = 0, chip_mode = 0, t0 = 0;
   logic [31:0] seed = 32'h1110;
   logic [15:0] rq[$], dq[$];
   logic rpend = 1'b0, dpend = 1'b0;
   always #2 sys_clk = ~sys_clk;
   pwdc_top #(.STEP_CYCLES(STEP)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .rx_sample(rx_sample), .rx_sample_en(rx_sample_en), .rx_half_bit(rx_half_bit),
      .rx_half_bit_en(rx_half_bit_en), .data_out(data_out), .rx_active(rx_active),
      .state_out(state_out), .cfg(cfg), .bw(bw));
   pwdc_host host (.sys_clk(sys_clk), .data_out(data_out), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      rq.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask : rd
   task automatic wait_st(input pwdc_state_t s);
      int n;
      n = 0;
      while (state_out !== s && n < 200) begin
         tick(1);
         n++;
      end
   endtask : wait_st
   // manchester chips: constant ones or alternating
   always @(posedge sys_clk) begin
      #1;
      rx_half_bit_en = chip_mode != 0;
      rx_half_bit = (chip_mode == 2) ? 1'b1 : ~rx_half_bit;
   end
   // results land one cycle after the strobe
   always @(negedge sys_clk) begin
      if (rpend) chk(reg_rdata, rq.pop_front(), "rdata");
      if (dpend) chk(data_out, dq.pop_front(), "stream");
      rpend = reg_rd;
      dpend = rx_sample_en && state_out == PWDC_HOST_RX;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      tick(10);
      rst_n = 1'b1;
      tick(3);
      chk(data_out, 1'b1, "reset data");
      chk(bw.if_khz, 9'h190, "reset if");
      rd(8'h55, 16'h0);
      for (int i = 0; i < 10; i++) begin
         logic [2:0] c, dv;
         logic f, m;
         c = 3'(i % 5);
         f = i >= 5;
         seed = lfsr(seed);
         m = seed[0];
         dv = seed[3:1];
         last02 = {3'h0, m, f, c};
         wr(8'h00, {1'b0, dv, 1'b0, 3'h4 - c});
         wr(8'h02, last02);
         tick(2);
         chk(bw.rx_bw_khz, PWDC_CHF_BW_KHZ[c] >> f, "rx bw");
         chk(bw.analog_bw_khz, PWDC_ABW_KHZ[f], "abw");
         chk(cfg.modulation_select, m, "mod");
         chk(cfg.fsk_deviation_select, m ? dv : 3'h0, "dev");
         chk(cfg.channel_filter_select, c, "chf");
         chk(cfg.if_filter_select, f, "if sel");
         chk(bw.if_khz, PWDC_IF_KHZ[f], "if khz");
         chk(cfg.demodulator_config_time_control, 3'h4 - c, "tctrl");
      end
      // window code 2 gives 8 steps, ratio code 1 gives two windows of wait
      wr(8'h17, 8'h02);
      wr(8'h18, 8'h01);
      rd(8'h17, 16'h0002);
      rd(8'h18, 16'h0001);
      for (int r = 0; r < 4; r++) begin
         wr(8'h0c, (r == 2) ? 8'h03 : 8'h07);
         wr(8'h0d, WTAB[r][7:0]);
         wr(8'h0e, WTAB[r][15:8]);
         chip_mode = (r == 0) ? 2 : 1;
         if (r == 3) begin
            rq.push_back(16'h0001);
            host.auto = 1'b1;
         end
         wr(8'h14, 8'h02);
         wait_st(PWDC_WAIT);
         chk(data_out, r == 0, "wait data");
         chk(rx_active, 1'b0, "rx wait");
         chip_mode = 0;
         if (r == 1) begin
            t0 = cyc;
            wait_st(PWDC_POLL);
            chk((cyc - t0) >= 16 * STEP && (cyc - t0) <= 16 * STEP + 1, 1'b1, "wait len");
            chk(data_out, 1'b1, "repoll");
            t0 = cyc;
            wait_st(PWDC_WAIT);
            chk((cyc - t0) >= 8 * STEP && (cyc - t0) <= 8 * STEP + 1, 1'b1, "poll len");
            chk(data_out, 1'b0, "rewait");
         end
         if (r < 3) begin
            rd(8'h13, {15'h0, r != 0});
            chk(state_out, PWDC_STANDBY, "clear state");
            chk(data_out, 1'b1, "clear data");
            chk(rx_active, 1'b0, "rx standby");
            rd(8'h14, 16'h0);
         end
      end
      wait_st(PWDC_HOST_RX);
      chk(state_out, PWDC_HOST_RX, "host rx");
      chk(rx_active, 1'b1, "rx on");
      tick(2);
      for (int k = 0; k < 40; k++) begin
         seed = lfsr(seed);
         rx_sample = seed[0];
         rx_sample_en = k[0];
         if (k[0]) dq.push_back({15'h0, seed[0]});
         tick(1);
      end
      rx_sample_en = 1'b0;
      wr(8'h02, 8'h1f);
      rd(8'h02, {8'h00, last02});
      wr(8'h14, 8'h00);
      tick(1);
      chk(state_out, PWDC_STANDBY, "rx off");
      tick(4);
      summarize();
   end
endmodule : pwdc_top_test
`default_nettype wire
